// file: inc/pbsp_pkg.sv
// Shared constants and carrier types of the pipelined burst memory port
package pbsp_pkg;
    // Word address width
    localparam int ADDR_W = 17;
    // Data bits and byte lanes
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_BITS = 8;
    // Stored word: data plus one parity bit per lane
    localparam int WORD_W = DATA_W + LANES;
    // Low address bits stepped by the burst counter
    localparam int BURST_W = 2;
    // Cycles from command to data on the bus
    localparam int DATA_LATENCY = 2;
    // Depth of the write log buffer
    localparam int LOG_DEPTH = 8;
    // Reset values
    localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic [LANES-1:0] PARITY_RESET = 4'h0;
    // Burst order encodings on the order select pin
    localparam logic ORDER_LINEAR = 1'b0;
    localparam logic ORDER_INTERLEAVED = 1'b1;

    // One command in flight through the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_write_n;
    } pbsp_cmd_t;

    // One committed write as reported to the log
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lane_write_n;
        logic [WORD_W-1:0] word;
    } pbsp_log_t;
endpackage

// file: rtl/pbsp_burst_step.sv
// Next low address pair of a burst in linear or interleaved order
`timescale 1ns/1ps
module pbsp_burst_step #(
    parameter int STEP_W = pbsp_pkg::BURST_W
) (
    // Burst start and beat index
    input wire logic [STEP_W-1:0] start_i,
    input wire logic [STEP_W-1:0] beat_i,
    // Order select, high for interleaved
    input wire logic order_i,
    // Low address bits of this beat
    output logic [STEP_W-1:0] low_o
);
    // Width must at least hold one bit
    if (STEP_W < 1)
    begin : g_bad_width
        $error("STEP_W must be at least 1");
    end

    // Combine start and beat index
    always_comb
    begin
        if (order_i == pbsp_pkg::ORDER_INTERLEAVED)
        begin
            low_o = start_i ^ beat_i;
        end
        else
        begin
            low_o = STEP_W'(start_i + beat_i);
        end
    end
endmodule

// file: rtl/pbsp_fifo.sv
// Small valid/ready FIFO with parameter width and depth
`timescale 1ns/1ps
module pbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = pbsp_pkg::LOG_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = $clog2(DEPTH);

    // Depth must be a power of two of at least two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2");
    end

    // Storage and pointers
    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] fill;
    logic push;
    logic pop;

    // Honest full and empty
    assign in_ready_o = (fill != (PTR_W + 1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = store[rd_ptr];

    // Storage write
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            store[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= PTR_W'(wr_ptr + 1'b1);
            end
            if (pop)
            begin
                rd_ptr <= PTR_W'(rd_ptr + 1'b1);
            end
            if (push && !pop)
            begin
                fill <= (PTR_W + 1)'(fill + 1'b1);
            end
            else if (pop && !push)
            begin
                fill <= (PTR_W + 1)'(fill - 1'b1);
            end
        end
    end
endmodule

// file: rtl/pbsp_port.sv
// Pipelined burst static memory port with two-cycle data latency
// How it works
// - Load captures address, direction; data two later
// - Advance high steps counter, same transfer type
// - Read/write select ignored during burst advance
// - Low advance while deselected stops any burst
// - Bus tri-states two cycles after deselect
// - Selected only when all three selects true
// - Clock gate high makes edge count absent except for log drain
// - Suspend holds pipeline, counter, read outputs, pins
// - Data outputs high impedance from reset, no edge needed
// - Lane write enables gate byte plus parity
// - Any lane mix writes exactly those lanes
// - Interleaved order is start xor beat
// - Linear order is start plus beat
// - Counter wraps after fourth beat, continues
// - New command every clock, no idle needed
// - Order select is static, high interleaved
// - Output enable high keeps pins floating
`timescale 1ns/1ps
module pbsp_port #(
    parameter int ADDR_W = pbsp_pkg::ADDR_W,
    parameter int LOG_DEPTH = pbsp_pkg::LOG_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Synchronous control
    input wire logic clock_gate_n_i,
    input wire logic advance_or_load_i,
    input wire logic read_write_i,
    input wire logic select_first_n_i,
    input wire logic select_second_n_i,
    input wire logic select_third_i,
    input wire logic [pbsp_pkg::LANES-1:0] lane_write_n_i,
    input wire logic burst_order_select_i,
    // Address
    input wire logic [ADDR_W-1:0] word_address_i,
    // Asynchronous output enable
    input wire logic output_enable_n_i,
    // Data and parity pins, split three ways
    input wire logic [pbsp_pkg::DATA_W-1:0] data_lines_i,
    input wire logic [pbsp_pkg::LANES-1:0] parity_lines_i,
    output logic [pbsp_pkg::DATA_W-1:0] data_lines_o,
    output logic [pbsp_pkg::LANES-1:0] parity_lines_o,
    output logic data_lines_oe_n_o,
    // Write log stream
    output logic log_valid_o,
    input wire logic log_ready_i,
    output pbsp_pkg::pbsp_log_t log_data_o,
    output logic log_space_o
);
    localparam int BW = pbsp_pkg::BURST_W;
    localparam int WW = pbsp_pkg::WORD_W;
    localparam int DW = pbsp_pkg::DATA_W;
    // Address width of the pipeline carrier
    localparam int PAW = pbsp_pkg::ADDR_W;

    // Address must hold the burst bits and fit the carrier
    if (ADDR_W <= BW || ADDR_W > PAW)
    begin : g_bad_addr
        $error("ADDR_W must be above BURST_W and at most the carrier width");
    end

    // Two stage latency is fixed by the pipeline below
    if (pbsp_pkg::DATA_LATENCY != 2)
    begin : g_bad_latency
        $error("pipeline is built for a latency of two");
    end

    // Merge pins into stored word under lane enables
    function automatic logic [WW-1:0] merge_lanes(
        input logic [WW-1:0] old_word,
        input logic [DW-1:0] data,
        input logic [pbsp_pkg::LANES-1:0] parity,
        input logic [pbsp_pkg::LANES-1:0] lane_n
    );
        logic [WW-1:0] word;
        word = old_word;
        for (int i = 0; i < pbsp_pkg::LANES; i++)
        begin
            if (!lane_n[i])
            begin
                word[i*pbsp_pkg::LANE_BITS +: pbsp_pkg::LANE_BITS] =
                    data[i*pbsp_pkg::LANE_BITS +: pbsp_pkg::LANE_BITS];
                word[DW + i] = parity[i];
            end
        end
        return word;
    endfunction

    // Memory array
    logic [WW-1:0] mem [0:(1 << ADDR_W)-1];

    // Input decode
    logic edge_live;
    logic selected;
    logic is_load;
    logic is_stop;
    logic is_advance;

    // Burst tracker
    logic burst_active;
    logic burst_write;
    logic [ADDR_W-1:0] burst_base;
    logic [BW-1:0] beat;
    logic [BW-1:0] next_beat;
    logic [BW-1:0] next_low;

    // Pipeline stages
    pbsp_pkg::pbsp_cmd_t next_cmd;
    pbsp_pkg::pbsp_cmd_t stage_one;
    pbsp_pkg::pbsp_cmd_t stage_two;

    // Output side
    logic drive;
    logic [WW-1:0] read_word;
    logic [WW-1:0] write_word;
    logic write_now;
    logic [WW-1:0] old_word;
    // Address of the due command, array width
    logic [ADDR_W-1:0] due_addr;

    // Log path
    pbsp_pkg::pbsp_log_t log_entry;

    // gate low lets the edge act
    assign edge_live = !clock_gate_n_i;
    // all three selects must be true
    assign selected = !select_first_n_i && !select_second_n_i &&
        select_third_i;
    assign is_load = edge_live && !advance_or_load_i && selected;
    // low advance with any select false
    assign is_stop = edge_live && !advance_or_load_i && !selected;
    assign is_advance = edge_live && advance_or_load_i;

    assign next_beat = BW'(beat + 1'b1);

    pbsp_burst_step #(
        .STEP_W(BW)
    ) u_step (
        .start_i(burst_base[BW-1:0]),
        .beat_i(next_beat),
        .order_i(burst_order_select_i),
        .low_o(next_low)
    );

    // Command formed this cycle
    always_comb
    begin
        next_cmd = '0;
        if (is_load)
        begin
            next_cmd.valid = 1'b1;
            next_cmd.write = !read_write_i;
            next_cmd.addr = PAW'(word_address_i);
            next_cmd.lane_write_n = lane_write_n_i;
        end
        else if (is_advance && burst_active)
        begin
            next_cmd.valid = 1'b1;
            next_cmd.write = burst_write;
            next_cmd.addr = PAW'({burst_base[ADDR_W-1:BW], next_low});
            // lanes sampled on each write beat
            next_cmd.lane_write_n = lane_write_n_i;
        end
    end

    // Burst tracker state
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            burst_active <= 1'b0;
            burst_write <= 1'b0;
            burst_base <= '0;
            beat <= pbsp_pkg::BEAT_RESET;
        end
        else if (edge_live)
        begin
            if (is_load)
            begin
                // Start a new burst at the loaded address
                burst_active <= 1'b1;
                burst_write <= !read_write_i;
                burst_base <= word_address_i;
                beat <= pbsp_pkg::BEAT_RESET;
            end
            else if (is_stop)
            begin
                burst_active <= 1'b0;
            end
            else if (burst_active)
            begin
                beat <= next_beat;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stage_one <= '0;
            stage_two <= '0;
        end
        else if (edge_live)
        begin
            stage_one <= next_cmd;
            stage_two <= stage_one;
        end
    end

    // Carrier address cut to the array's width
    assign due_addr = stage_two.addr[ADDR_W-1:0];
    // Write data merge for the command now due
    assign old_word = mem[due_addr];
    assign write_now = edge_live && stage_two.valid && stage_two.write;
    assign write_word = merge_lanes(old_word, data_lines_i,
        parity_lines_i, stage_two.lane_write_n);

    // Memory write, two cycles after command
    always_ff @(posedge clk_i)
    begin
        if (write_now)
        begin
            mem[due_addr] <= write_word;
        end
    end

    // Read output register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            read_word <= {pbsp_pkg::PARITY_RESET, pbsp_pkg::DATA_RESET};
        end
        else if (edge_live && stage_two.valid && !stage_two.write)
        begin
            // read data out two cycles later
            read_word <= mem[due_addr];
        end
    end

    // Drive flag for the data pins
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            drive <= 1'b0;
        end
        else if (edge_live)
        begin
            drive <= stage_two.valid && !stage_two.write;
        end
    end

    // Pin outputs from the read register
    assign data_lines_o = read_word[DW-1:0];
    assign parity_lines_o = read_word[WW-1:DW];
    assign data_lines_oe_n_o = !(drive && !output_enable_n_i);

    // Entry for each committed write
    always_comb
    begin
        log_entry.addr = stage_two.addr;
        log_entry.lane_write_n = stage_two.lane_write_n;
        log_entry.word = write_word;
    end

    // Write log buffer
    pbsp_fifo #(
        .WIDTH($bits(pbsp_pkg::pbsp_log_t)),
        .DEPTH(LOG_DEPTH)
    ) u_log (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(write_now),
        .in_data_i(log_entry),
        .in_ready_o(log_space_o),
        .out_valid_o(log_valid_o),
        .out_ready_i(log_ready_i),
        .out_data_o(log_data_o)
    );
endmodule

// file: sim/pbsp_port_properties.sv
// Pin-level concurrent checks of the burst memory port
`timescale 1ns/1ps
module pbsp_port_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control pins
    input wire logic clock_gate_n_i,
    input wire logic advance_or_load_i,
    input wire logic read_write_i,
    input wire logic select_first_n_i,
    input wire logic select_second_n_i,
    input wire logic select_third_i,
    input wire logic output_enable_n_i,
    // Observed outputs
    input wire logic [pbsp_pkg::DATA_W-1:0] data_lines_o,
    input wire logic [pbsp_pkg::LANES-1:0] parity_lines_o,
    input wire logic data_lines_oe_n_o,
    input wire logic log_valid_o,
    input wire logic log_space_o
);
    // Command classes of one edge
    logic sel;
    logic ld;
    logic stp;
    logic adv;
    logic live;
    // Selected only with all three selects true
    assign sel = !select_first_n_i && !select_second_n_i && select_third_i;
    assign live = !clock_gate_n_i;
    assign ld = live && !advance_or_load_i && sel;
    assign stp = live && !advance_or_load_i && !sel;
    assign adv = live && advance_or_load_i;
    // One clock domain for every check
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_reset_idle;
        $fell(rst_i) |-> data_lines_oe_n_o && log_space_o && !log_valid_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("Outputs not idle after reset");
    property p_oe_float;
        output_enable_n_i |-> data_lines_oe_n_o;
    endproperty
    a_oe_float: assert property (p_oe_float)
        else $error("Pins driven with output enable high");
    property p_suspend;
        clock_gate_n_i |=> $stable(data_lines_o) && $stable(parity_lines_o);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("Read data moved on a suspended edge");
    property p_read_lat;
        ld && read_write_i ##1 live [*2] ##1 !output_enable_n_i
            |-> !data_lines_oe_n_o;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("Read data not driven two edges after load");
    property p_write_log;
        ld && !read_write_i ##1 live [*2] |=> log_valid_o;
    endproperty
    a_write_log: assert property (p_write_log)
        else $error("Write not committed two edges after load");
    property p_burst_dir;
        ld && read_write_i ##1 adv && !read_write_i ##1 live [*2]
            ##1 !output_enable_n_i |-> !data_lines_oe_n_o;
    endproperty
    a_burst_dir: assert property (p_burst_dir)
        else $error("Burst read beat turned into a write");
    property p_stop_float;
        stp ##1 live [*2] |=> data_lines_oe_n_o;
    endproperty
    a_stop_float: assert property (p_stop_float)
        else $error("Pins driven two edges after deselect");
    property p_noop;
        stp ##1 adv ##1 live [*2] |=> data_lines_oe_n_o;
    endproperty
    a_noop: assert property (p_noop)
        else $error("Advance after deselect drove the pins");
endmodule

bind pbsp_port pbsp_port_properties i_pbsp_port_properties (
    .clk_i, .rst_i, .clock_gate_n_i, .advance_or_load_i, .read_write_i,
    .select_first_n_i, .select_second_n_i, .select_third_i,
    .output_enable_n_i, .data_lines_o, .parity_lines_o,
    .data_lines_oe_n_o, .log_valid_o, .log_space_o
);

// file: sim/pbsp_host_model.sv
// Host-side driver of write data on the shared lines
`timescale 1ns/1ps
module pbsp_host_model (
    // Clock
    input wire logic clk_i,
    // Write phase request from the host sequencer
    input wire logic drive_i,
    input wire logic [pbsp_pkg::WORD_W-1:0] word_i,
    // Data and parity toward the port
    output logic [pbsp_pkg::DATA_W-1:0] data_lines_o,
    output logic [pbsp_pkg::LANES-1:0] parity_lines_o
);
    // Level left on the lines last cycle
    logic [pbsp_pkg::WORD_W-1:0] last = '0;
    // Remember the lines each edge
    always_ff @(posedge clk_i)
    begin
        last <= {parity_lines_o, data_lines_o};
    end
    // data on the write phase
    // Released lines toggle so stale data never matches
    assign {parity_lines_o, data_lines_o} = drive_i ? word_i : ~last;
endmodule

// file: sim/pbsp_port_bench.sv
// Self-checking bench of the burst memory port
`timescale 1ns/1ps
module pbsp_port_bench;
    // Row: gate adv rw oe, sel, lanes, addr, drive expect, wv, ev
    typedef struct packed {
        logic g, adv, rw, oe;
        logic [3:0] sel, ln, a, fl, wv, ev;
    } pbsp_row_t;
    // Narrow address for a short table
    localparam int AW = 4;
    // Word after lanes 0 and 2 take all ones
    localparam logic [35:0] MRG = 36'h7_22FF_22FF;
    // Logged write addresses, low nibble first
    localparam logic [31:0] LOG_ADDRS = 32'h3222_4765;
    // Clock, reset and stimulus
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic cg = 1'b1, al = 1'b0, rw = 1'b1, oe = 1'b0;
    logic s1 = 1'b1, s2 = 1'b1, s3 = 1'b0;
    logic ord = pbsp_pkg::ORDER_LINEAR;
    logic [3:0] ln = 4'hF;
    logic [AW-1:0] ad = 4'h0;
    logic drv = 1'b0, lrdy = 1'b0;
    logic [35:0] wrd = 36'h0;
    // Pins and log seen from the port
    logic [31:0] dl, q;
    logic [3:0] pl, qp;
    logic qoe, lv, ls;
    pbsp_pkg::pbsp_log_t ld;
    int fails = 0;
    int total_checks = 0;
    // Plain cycles: bursts, stops, suspend, wrap
    pbsp_row_t rows [22] = '{
        28'h0105000, 28'h4100000, 28'h4100850, 28'h4100860,
        28'h0300870, 28'h4100840, 28'h2106000, 28'h4100000,
        28'h6100406, 28'h8100406, 28'h4100407, 28'h4100404,
        28'h0000405, 28'h0102406, 28'h2105000, 28'h2107820,
        28'h1500000, 28'h0500407, 28'h0500000, 28'h2102000,
        28'h0500000, 28'h0500402};
    pbsp_port #(.ADDR_W(AW)) i_pbsp_port (
        .clk_i(clk_i), .rst_i(rst_i), .clock_gate_n_i(cg),
        .advance_or_load_i(al), .read_write_i(rw),
        .select_first_n_i(s1), .select_second_n_i(s2), .select_third_i(s3),
        .lane_write_n_i(ln), .burst_order_select_i(ord),
        .word_address_i(ad), .output_enable_n_i(oe),
        .data_lines_i(dl), .parity_lines_i(pl), .data_lines_o(q),
        .parity_lines_o(qp), .data_lines_oe_n_o(qoe), .log_valid_o(lv),
        .log_ready_i(lrdy), .log_data_o(ld), .log_space_o(ls));
    pbsp_host_model i_pbsp_host_model (
        .clk_i(clk_i), .drive_i(drv), .word_i(wrd),
        .data_lines_o(dl), .parity_lines_o(pl));
    // Free-running clock, 25 ns period
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Compare and count
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task test_done;
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // One cycle: drive at falling edge, check after rising edge
    task step(input pbsp_row_t r, input logic [35:0] wv, ev);
        @(negedge clk_i);
        {cg, al, rw, oe, s1, s2, s3, ln, ad, drv} =
            {r.g, r.adv, r.rw, r.oe, r.sel[2:0], r.ln, r.a, r.fl[3]};
        wrd = wv;
        @(posedge clk_i);
        #1;
        chk(qoe, !r.fl[2]);
        if (r.fl[2])
            chk({qp, q}, ev);
    endtask
    // Row with words made of its nibbles
    task row(input pbsp_row_t r);
        step(r, {9{r.wv}}, {9{r.ev}});
    endtask
    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        foreach (rows[i])
            row(rows[i]);
        // Partial lanes, then no lanes, then read back
        row(28'h01A2000);
        row(28'h01F2000);
        step(28'h0500800, 36'hF_FFFF_FFFF, 36'h0);
        step(28'h0500800, 36'h0, 36'h0);
        row(28'h2102000);
        row(28'h0500000);
        step(28'h0500400, 36'h0, MRG);
        // Fill the log until it refuses
        row(28'h0103000);
        row(28'h0109000);
        row(28'h0500830);
        row(28'h0500890);
        chk(ls, 1'b0);
        // Drain in order, dropped entry absent
        @(negedge clk_i);
        lrdy = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            chk(lv, 1'b1);
            chk(ld, {17'(LOG_ADDRS[4*i +: 4]),
                (i == 5) ? 4'hA : (i == 6) ? 4'hF : 4'h0,
                (i == 5 || i == 6) ? MRG : {9{LOG_ADDRS[4*i +: 4]}}});
            @(negedge clk_i);
        end
        lrdy = 1'b0;
        chk(lv, 1'b0);
        // Mid-run reset, order changed only while held
        rst_i = 1'b1;
        ord = pbsp_pkg::ORDER_INTERLEAVED;
        #1;
        chk({qoe, ls, lv}, 3'h6);
        @(negedge clk_i);
        rst_i = 1'b0;
        row(28'h2105000);
        row(28'h4100000);
        row(28'h4100405);
        row(28'h4100404);
        row(28'h0500407);
        row(28'h0500406);
        test_done();
    end
endmodule
